// File: hdl/bttc_consts.svh
// Constants for the bit-table transfer and compare datapath
`ifndef BTTC_CONSTS_SVH
`define BTTC_CONSTS_SVH
`define BTTC_WORD_BITS 16
`define BTTC_MAX_WORDS 64
`define BTTC_TAB_BITS 1024
`define BTTC_LEN_MIN 7'h01
`define BTTC_LEN_MAX 7'h40
`define BTTC_PTR_RST 16'h0000
`endif

// File: hdl/bttc_datapath.sv
// Bit-table transfer, bit-file compare and signed greater-than datapath
// How it works
// (RL1) Enabled table-to-bit with pointer in range copies the table bit; flag low.
// (RL2) Enable low: no transfer, flag low.
// (RL3) Enabled bit-to-table writes source bit into the pointed table bit.
// (RL4) Bit-to-table with pointer out of range changes nothing; flag high.
// (RL5) Table length runs 1 to 64 words; every length is supported.
// (RL6) Pointer zero is the first bit; valid pointers are 0 to n*16-1.
// (RL7) Compare scans both tables from the bit after the stored pointer.
// (RL8) First differing bit: its position goes to the pointer; flag high.
// (RL9) Stored pointer out of range: scan starts at bit zero.
// (RL10) Scan wraps from the last table bit to the first.
// (RL11) No difference by the original position: flag low, pointer kept.
// (RL12) Enable low: compare does nothing, pointer kept, flag low.
// (RL13) Greater-than flag high only when enabled and first operand is larger.
// (RL14) Greater-than treats both operands as signed 16-bit values.
// (RL15) Greater-than never alters its operands.
// (RL16) Pointer p selects word p/16, bit p%16, bit zero the LSB.
`timescale 1ns/100ps
`default_nettype none
`include "bttc_consts.svh"
module bttc_datapath
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Operation request
	input wire logic start,
	input wire bttc_pkg::bttc_op_e op,
	input wire logic rung_en,
	input wire logic [6:0] table_len,
	input wire logic [15:0] bit_ptr,
	input wire logic src_bit,
	input wire logic [15:0] opnd_a,
	input wire logic [15:0] opnd_b,
	// Table word load
	input wire logic load_we,
	input wire logic load_sel,
	input wire logic [5:0] load_addr,
	input wire logic [15:0] load_data,
	// Table word readback
	input wire logic rd_sel,
	input wire logic [5:0] rd_addr,
	// Results
	output logic busy,
	output logic done,
	output logic flag,
	output logic dest_bit,
	output logic [15:0] ptr_out,
	output logic [15:0] rd_data
);
	bttc_pkg::bttc_state_s s_q;
	bttc_pkg::bttc_state_s s_d;
	logic [10:0] total;
	logic ptr_in;
	logic [9:0] ptr_lo;
	logic [10:0] pos_next;
	logic sel_bit;
	logic gt_now;

	// Out-of-range lengths give an empty table, so every pointer is over
	assign total = (table_len >= `BTTC_LEN_MIN && table_len <= `BTTC_LEN_MAX)
		? {table_len, 4'h0} : 11'h000; // RL5
	assign ptr_in = bit_ptr < {5'h00, total}; // RL6
	assign ptr_lo = bit_ptr[9:0]; // RL16
	assign pos_next = {1'b0, s_q.pos} + 11'h001;
	assign sel_bit = s_q.tab_a[ptr_lo];
	// Operands are only read, never stored back
	assign gt_now = $signed(opnd_a) > $signed(opnd_b); // RL14 RL15

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (rd_sel)
			s_d.rd = s_q.tab_b[{rd_addr, 4'h0} +: `BTTC_WORD_BITS];
		else
			s_d.rd = s_q.tab_a[{rd_addr, 4'h0} +: `BTTC_WORD_BITS];
		case (s_q.state)
			bttc_pkg::BTTC_ST_IDLE:
			begin
				// Loads are refused mid-scan so the compared tables stay still
				if (load_we)
				begin
					if (load_sel)
						s_d.tab_b[{load_addr, 4'h0} +: `BTTC_WORD_BITS] = load_data;
					else
						s_d.tab_a[{load_addr, 4'h0} +: `BTTC_WORD_BITS] = load_data;
				end
				if (start)
				begin
					s_d.done = 1'b1;
					s_d.flag = 1'b0; // RL2 RL12
					if (rung_en)
					begin
						case (op)
							bttc_pkg::BTTC_OP_T2B:
							begin
								if (ptr_in)
									s_d.dest = sel_bit; // RL1
								else
									s_d.flag = 1'b1;
							end
							bttc_pkg::BTTC_OP_B2T:
							begin
								if (ptr_in)
									s_d.tab_a[ptr_lo] = src_bit; // RL3
								else
									s_d.flag = 1'b1; // RL4
							end
							bttc_pkg::BTTC_OP_GT:
								s_d.flag = gt_now; // RL13
							default:
							begin
								if (total != 11'h000)
								begin
									s_d.done = 1'b0;
									s_d.busy = 1'b1;
									s_d.state = bttc_pkg::BTTC_ST_SCAN;
									s_d.ptr = bit_ptr;
									s_d.cnt = 11'h000;
									s_d.total = total;
									if (!ptr_in)
										s_d.pos = 10'h000; // RL9
									else if ({1'b0, ptr_lo} + 11'h001 == total)
										s_d.pos = 10'h000; // RL10
									else
										s_d.pos = ptr_lo + 10'h001; // RL7
								end
							end
						endcase
					end
				end
			end
			default:
			begin
				if (s_q.tab_a[s_q.pos] != s_q.tab_b[s_q.pos])
				begin
					s_d.ptr = {6'h00, s_q.pos}; // RL8
					s_d.flag = 1'b1;
					s_d.done = 1'b1;
					s_d.busy = 1'b0;
					s_d.state = bttc_pkg::BTTC_ST_IDLE;
				end
				else if (s_q.cnt == s_q.total - 11'h001)
				begin
					// Original position checked last; pointer left as it was
					s_d.flag = 1'b0; // RL11
					s_d.done = 1'b1;
					s_d.busy = 1'b0;
					s_d.state = bttc_pkg::BTTC_ST_IDLE;
				end
				else
				begin
					s_d.cnt = s_q.cnt + 11'h001;
					if (pos_next == s_q.total)
						s_d.pos = 10'h000; // RL10
					else
						s_d.pos = pos_next[9:0];
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign busy = s_q.busy;
	assign done = s_q.done;
	assign flag = s_q.flag;
	assign dest_bit = s_q.dest;
	assign ptr_out = s_q.ptr;
	assign rd_data = s_q.rd;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	AST_DISABLED_FLAG_LOW: // RL2
	assert property (start && !busy && !rung_en |=> done && !flag
		&& ptr_out == $past(ptr_out))
	else $error("disabled operation raised flag or moved pointer");

	AST_T2B_COPY: // RL1
	assert property (start && !busy && rung_en
		&& op == bttc_pkg::BTTC_OP_T2B && ptr_in
		|=> done && !flag && dest_bit == $past(sel_bit))
	else $error("table-to-bit did not copy selected bit");

	AST_B2T_WRITE: // RL3
	assert property (start && !busy && rung_en
		&& op == bttc_pkg::BTTC_OP_B2T && ptr_in
		|=> !flag && s_q.tab_a[$past(ptr_lo)] == $past(src_bit))
	else $error("bit-to-table did not write source bit");

	AST_B2T_OVER: // RL4
	assert property (start && !busy && rung_en && !load_we
		&& op == bttc_pkg::BTTC_OP_B2T && !ptr_in
		|=> flag && s_q.tab_a == $past(s_q.tab_a))
	else $error("bit-to-table over range changed table or kept flag low");

	AST_GT_RESULT: // RL13
	assert property (start && !busy && rung_en && op == bttc_pkg::BTTC_OP_GT
		|=> done && flag == $past(gt_now))
	else $error("greater-than result wrong");

	AST_CMP_START_ZERO: // RL9
	assert property (start && !busy && rung_en && op == bttc_pkg::BTTC_OP_CMP
		&& !ptr_in && total != 11'h000 |=> busy && s_q.pos == 10'h000)
	else $error("out of range compare did not start at bit zero");

	AST_CMP_HIT: // RL8
	assert property (busy && s_q.tab_a[s_q.pos] != s_q.tab_b[s_q.pos]
		|=> done && flag && !busy && ptr_out == {6'h00, $past(s_q.pos)})
	else $error("compare hit not recorded");

	AST_CMP_WRAP: // RL10
	assert property (busy && !s_d.done && pos_next == s_q.total
		|=> s_q.pos == 10'h000)
	else $error("compare scan did not wrap");

	AST_CMP_MISS: // RL11
	assert property (busy && s_d.done && s_q.tab_a[s_q.pos] == s_q.tab_b[s_q.pos]
		|=> !flag && ptr_out == $past(ptr_out))
	else $error("compare miss changed pointer or raised flag");

	AST_CMP_BOUND: // RL11
	assert property (busy |-> s_q.cnt < s_q.total)
	else $error("compare scanned beyond table length");
endmodule : bttc_datapath
`default_nettype wire

// File: hdl/bttc_pkg.sv
// Types for the bit-table transfer and compare datapath
`default_nettype none
package bttc_pkg;
	typedef enum logic [1:0] {
		BTTC_OP_T2B,
		BTTC_OP_B2T,
		BTTC_OP_CMP,
		BTTC_OP_GT
	} bttc_op_e;

	typedef enum logic {
		BTTC_ST_IDLE,
		BTTC_ST_SCAN
	} bttc_state_e;

	typedef struct packed {
		bttc_state_e state;
		logic [1023:0] tab_a;
		logic [1023:0] tab_b;
		logic [9:0] pos;
		logic [10:0] cnt;
		logic [10:0] total;
		logic [15:0] ptr;
		logic flag;
		logic done;
		logic busy;
		logic dest;
		logic [15:0] rd;
	} bttc_state_s;
endpackage : bttc_pkg
`default_nettype wire

// File: verification/bttc_seq.sv
// Scan sequencer stand-in that hands requests to the block
`timescale 1ns/100ps
`default_nettype none
module bttc_seq
(
	// Request
	input wire logic req,
	input wire logic busy,
	// To block
	output logic start
);
	// Masked while busy; a request raised during a scan is dropped, not queued
	assign start = req & ~busy;
endmodule : bttc_seq
`default_nettype wire

// File: verification/tb_bit_table_transfer_compare.sv
// Self-checking bench for the bit-table transfer and compare datapath
`timescale 1ns/100ps
`default_nettype none
module tb_bit_table_transfer_compare;
	logic clk = 1'b0, reset_n = 1'b0, req = 1'b0, rung_en = 1'b0;
	logic src_bit = 1'b0, load_we = 1'b0, load_sel = 1'b0, rd_sel = 1'b0;
	bttc_pkg::bttc_op_e op = bttc_pkg::BTTC_OP_T2B;
	logic [6:0] table_len = 7'h01;
	logic [15:0] bit_ptr = 16'h0000, opnd_a = 16'h0000, opnd_b = 16'h0000;
	logic [15:0] load_data = 16'h0000;
	logic [5:0] load_addr = 6'h00, rd_addr = 6'h00;
	logic start, busy, done, flag, dest_bit;
	logic [15:0] ptr_out, rd_data;
	int failures = 0, comparisons = 0;
	bttc_seq seq (.req(req), .busy(busy), .start(start));
	bttc_datapath DUT (.clk(clk), .reset_n(reset_n), .start(start), .op(op),
		.rung_en(rung_en), .table_len(table_len), .bit_ptr(bit_ptr),
		.src_bit(src_bit), .opnd_a(opnd_a), .opnd_b(opnd_b),
		.load_we(load_we), .load_sel(load_sel), .load_addr(load_addr),
		.load_data(load_data), .rd_sel(rd_sel), .rd_addr(rd_addr),
		.busy(busy), .done(done), .flag(flag), .dest_bit(dest_bit),
		.ptr_out(ptr_out), .rd_data(rd_data));
	initial
	begin
		forever #4 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic run(input bttc_pkg::bttc_op_e o, input logic en,
		input logic [6:0] n, input logic [15:0] p);
		int k;
		@(posedge clk);
		#1;
		op = o;
		rung_en = en;
		table_len = n;
		bit_ptr = p;
		req = 1'b1;
		@(posedge clk);
		#1;
		req = 1'b0;
		if (o == bttc_pkg::BTTC_OP_CMP && en && n != 7'h00)
			check("busy", busy, 16'h0001);
		// A full scan of 64 words takes just over 1024 cycles
		for (k = 0; k < 1100 && done !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		if (k == 1100)
		begin
			failures++;
			tally_and_finish();
		end
	endtask : run
	task automatic load(input logic s, input logic [5:0] a,
		input logic [15:0] d);
		@(posedge clk);
		#1;
		load_we = 1'b1;
		load_sel = s;
		load_addr = a;
		load_data = d;
		@(posedge clk);
		#1;
		load_we = 1'b0;
	endtask : load
	task automatic readw(input logic [5:0] a, input logic [15:0] exp);
		rd_addr = a;
		@(posedge clk);
		#1;
		check("table word", rd_data, exp);
	endtask : readw
	task automatic t2b_case;
		load(1'b0, 6'h02, 16'h4000);
		run(bttc_pkg::BTTC_OP_T2B, 1'b1, 7'h05, 16'h002E);
		check("t2b flag", flag, 16'h0000);
		check("t2b dest", dest_bit, 16'h0001);
		run(bttc_pkg::BTTC_OP_T2B, 1'b1, 7'h05, 16'h002D);
		check("t2b dest zero", dest_bit, 16'h0000);
		run(bttc_pkg::BTTC_OP_T2B, 1'b1, 7'h05, 16'h0050);
		check("t2b over flag", flag, 16'h0001);
		run(bttc_pkg::BTTC_OP_T2B, 1'b0, 7'h05, 16'h002E);
		check("t2b off flag", flag, 16'h0000);
	endtask : t2b_case
	task automatic b2t_case;
		src_bit = 1'b1;
		run(bttc_pkg::BTTC_OP_B2T, 1'b1, 7'h05, 16'h004D);
		check("b2t flag", flag, 16'h0000);
		readw(6'h04, 16'h2000);
		run(bttc_pkg::BTTC_OP_B2T, 1'b1, 7'h05, 16'h0050);
		check("b2t over flag", flag, 16'h0001);
		readw(6'h05, 16'h0000);
		run(bttc_pkg::BTTC_OP_B2T, 1'b0, 7'h05, 16'h004C);
		check("b2t off flag", flag, 16'h0000);
		readw(6'h04, 16'h2000);
		src_bit = 1'b0;
		run(bttc_pkg::BTTC_OP_B2T, 1'b1, 7'h05, 16'h004D);
		readw(6'h04, 16'h0000);
		src_bit = 1'b1;
		run(bttc_pkg::BTTC_OP_B2T, 1'b1, 7'h40, 16'h03FF);
		readw(6'h3F, 16'h8000);
	endtask : b2t_case
	task automatic cmp_case;
		load(1'b1, 6'h02, 16'h0001);
		load(1'b1, 6'h00, 16'h0001);
		rd_sel = 1'b1;
		readw(6'h02, 16'h0001);
		rd_sel = 1'b0;
		run(bttc_pkg::BTTC_OP_CMP, 1'b1, 7'h04, 16'h0000);
		check("cmp flag", flag, 16'h0001);
		check("cmp ptr", ptr_out, 16'h0020);
		run(bttc_pkg::BTTC_OP_CMP, 1'b1, 7'h04, 16'h0020);
		check("cmp ptr", ptr_out, 16'h002E);
		run(bttc_pkg::BTTC_OP_CMP, 1'b1, 7'h04, 16'h002E);
		check("cmp wrap ptr", ptr_out, 16'h0000);
		run(bttc_pkg::BTTC_OP_CMP, 1'b1, 7'h04, 16'h0064);
		check("cmp over ptr", ptr_out, 16'h0000);
		run(bttc_pkg::BTTC_OP_CMP, 1'b0, 7'h04, 16'h0005);
		check("cmp off flag", flag, 16'h0000);
		check("cmp off ptr", ptr_out, 16'h0000);
		load(1'b0, 6'h00, 16'h0001);
		run(bttc_pkg::BTTC_OP_CMP, 1'b1, 7'h01, 16'h0005);
		check("cmp same flag", flag, 16'h0000);
		check("cmp same ptr", ptr_out, 16'h0005);
	endtask : cmp_case
	task automatic gt(input logic [15:0] a, input logic [15:0] b,
		input logic en, input logic exp);
		opnd_a = a;
		opnd_b = b;
		run(bttc_pkg::BTTC_OP_GT, en, 7'h01, 16'h0000);
		check("gt flag", flag, {15'h0000, exp});
	endtask : gt
	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		reset_n = 1'b1;
		t2b_case();
		b2t_case();
		cmp_case();
		gt(16'h0001, 16'h0000, 1'b1, 1'b1);
		gt(16'h0005, 16'h0005, 1'b1, 1'b0);
		gt(16'h0001, 16'h0000, 1'b0, 1'b0);
		gt(16'h8000, 16'h7FFF, 1'b1, 1'b0);
		gt(16'h7FFF, 16'h8000, 1'b1, 1'b1);
		gt(16'hFFFF, 16'h8000, 1'b1, 1'b1);
		tally_and_finish();
	end
endmodule : tb_bit_table_transfer_compare
`default_nettype wire
